// ---- logic/lmd_pkg.sv ----
// Constants, register map and carrier types of the LED scan/PWM dimmer.
// Assumes a 50 MHz core clock and an 8-bit register port.
package lmd_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NUM_OUT = 4;
  localparam int NUM_LED = 16;
  localparam logic [5:0] ADDR_CFG_MODE = 6'h00;
  localparam logic [5:0] ADDR_CFG_SCAN = 6'h01;
  localparam logic [5:0] ADDR_CFG_DRIVE = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_PWM_COUNT = 6'h04;
  localparam logic [1:0] BANK_DOT = 2'h1;
  localparam logic [1:0] BANK_PWM = 2'h2;
  localparam logic [1:0] BANK_SHAPE = 2'h3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int RATE_BIT = 3;
  localparam int MIX_LSB = 4;
  localparam int CLAMP_DIS_BIT = 0;
  localparam int CLAMP_SEL_BIT = 1;
  localparam int VMID_LSB = 2;
  localparam int BLANK_SEL_BIT = 4;
  localparam int FULL_SCALE_BIT = 5;
  localparam int SYNC_OUT_BIT = 6;
  localparam int ALIGN_LSB = 0;
  localparam int EXP_BIT = 2;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] SCAN_RST = 8'he4;
  localparam logic [7:0] DRIVE_RST = 8'h40;
  localparam logic [7:0] DOT_RST = 8'h80;
  localparam logic [7:0] PWM_RST = 8'h00;
  localparam logic [7:0] SHAPE_RST = 8'h00;
  localparam logic [2:0] MODE_DIRECT = 3'h0;
  localparam logic [2:0] MODE_MIX_BASE = 3'h4;
  localparam logic [1:0] ALIGN_MID = 2'h1;
  localparam logic [1:0] ALIGN_BWD = 2'h2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int OSC_KHZ = 6000;
  localparam logic [15:0] OSC_STEP = 16'(OSC_KHZ);
  localparam logic [15:0] OSC_WRAP = 16'(CLK_KHZ - OSC_KHZ);
  localparam int BLANK_SHORT_NS = 1000;
  localparam int BLANK_LONG_NS = 2000;
  localparam logic [6:0] BLANK_SHORT_CYC = 7'((BLANK_SHORT_NS * CLK_KHZ + 999999) / 1000000);
  localparam logic [6:0] BLANK_LONG_CYC = 7'((BLANK_LONG_NS * CLK_KHZ + 999999) / 1000000);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    LMD_DIM = 1'b0,
    LMD_BLANK = 1'b1
  } lmd_scan_state_t;

  typedef struct packed {
    logic [3:0] scanOn;
    logic [3:0] sinkOn;
    logic [3:0] clampOn;
  } lmd_drive_t;

endpackage

// ---- logic/lmd_scan_pwm.sv ----
// Scan sequencer, PWM dimmer and drive decoder for a four-output LED array.
// Assumes a synchronous register master on core_clk and an async sync pin.
//
// Function
// - Mode 0 drives four LEDs directly, one per sink, no scanning.
// - Modes 1 to 4 scan a matrix with one to four slots.
// - Each slot enables the output named in its scan order field.
// - With switch k active, dots 0,1,2 sink on outputs k+1,k+2,k+3 mod four.
// - Modes 5 to 7 mix direct outputs with a one to three slot matrix.
// - Mixed mode direct-select mask picks direct sinks; others use matrix dot settings.
// - Deghosting on after reset; setting disable bit turns clamping off.
// - Clamp window is PWM off time or blank time only, by select bit.
// - Two-bit field picks one of four clamp levels for all outputs.
// - One global full-scale bit sets sink maximum current, reset low.
// - Per-LED eight-bit current level, reset 80h, scales peak current.
// - Eight-bit PWM per LED at 24 or 12 kHz by rate bit.
// - PWM time base comes from internal 6 MHz oscillator unless imported.
// - Sync drive bit exports the PWM clock or imports it on sync pin.
// - Per-LED alignment field picks forward, middle or backward pulse placement.
// - Forward pulse rises at period start and lasts the duty.
// - Middle pulse is centred on the period midpoint.
// - Backward pulse falls at period end.
// - Per-LED curve bit picks linear or exponential duty mapping.
// - Matrix dots conduct only in their own slot, dividing average current.
// - One output is scan switch at a time; slots advance in sequence.
// - Each slot lasts one PWM period then a 1 or 2 us blank.
`timescale 1ns/1ns

module lmd_scan_pwm
  import lmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  input wire logic syncIn,
  output logic syncOut,
  output logic syncOe_n,
  output lmd_drive_t drive,
  output logic [4*NUM_OUT-1+16:0] sinkLevel,
  output logic fullScale,
  output logic [1:0] vmidSel
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // LED storage index: 0..3 direct, 4+3k+j matrix dot j of switch k
  function automatic logic [3:0] ledIndex(input logic [1:0] outNo, input logic [1:0] sw,
                                          input logic direct);
    logic [1:0] dot;
    logic [3:0] base;
    dot = 2'(outNo - sw - 2'h1);
    base = 4'(4'h4 + 4'(sw) * 4'h3);
    if (direct) begin
      ledIndex = {2'h0, outNo};
    end else begin
      ledIndex = 4'(base + {2'h0, dot});
    end
  endfunction

  // Perceptual curve, cubic shape with both ends fixed
  function automatic logic [7:0] expCurve(input logic [7:0] s);
    logic [23:0] cube;
    cube = 24'(s) * 24'(s) * 24'(s);
    if (s == 8'hff) begin
      expCurve = 8'hff;
    end else begin
      expCurve = cube[23:16];
    end
  endfunction

  // Duty in ticks; full scale stretches to the whole period
  function automatic logic [8:0] dutyOf(input logic [7:0] s, input logic expo);
    logic [7:0] eff;
    eff = expo ? expCurve(s) : s;
    dutyOf = (eff == 8'hff) ? 9'h100 : {1'b0, eff};
  endfunction

  // Pulse window test for the given alignment
  function automatic logic pwmOn(input logic [7:0] cnt, input logic [8:0] duty,
                                 input logic [1:0] align);
    logic [8:0] start;
    logic [8:0] gap;
    gap = 9'(9'h100 - duty);
    if (align == ALIGN_BWD) begin
      start = gap;
    end else if (align == ALIGN_MID) begin
      start = {1'b0, gap[8:1]};
    end else begin
      start = 9'h000;
    end
    pwmOn = ({1'b0, cnt} >= start) && ({1'b0, cnt} < 9'(start + duty));
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] modeCfg_q;
  logic [7:0] scanCfg_q;
  logic [7:0] driveCfg_q;
  logic [7:0] dotLevel_q [NUM_LED];
  logic [7:0] pwmSet_q [NUM_LED];
  logic [7:0] shape_q [NUM_LED];
  logic [7:0] regRdData_q;

  wire wrMode = regWrEn && (regAddr == ADDR_CFG_MODE);
  wire wrScan = regWrEn && (regAddr == ADDR_CFG_SCAN);
  wire wrDrive = regWrEn && (regAddr == ADDR_CFG_DRIVE);
  wire wrDot = regWrEn && (regAddr[5:4] == BANK_DOT);
  wire wrPwm = regWrEn && (regAddr[5:4] == BANK_PWM);
  wire wrShape = regWrEn && (regAddr[5:4] == BANK_SHAPE);
  wire [3:0] regIdx = regAddr[3:0];

  // Global configuration, deghost enabled from reset
  // clamp enable default
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeCfg_q <= MODE_RST;
      scanCfg_q <= SCAN_RST;
      driveCfg_q <= DRIVE_RST;
    end else begin
      if (wrMode) modeCfg_q <= regWrData;
      if (wrScan) scanCfg_q <= regWrData;
      if (wrDrive) driveCfg_q <= regWrData;
    end
  end

  // Per-LED settings: current level, PWM setting, alignment and curve
  // level reset value
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_LED; i++) begin
        dotLevel_q[i] <= DOT_RST;
        pwmSet_q[i] <= PWM_RST;
        shape_q[i] <= SHAPE_RST;
      end
    end else begin
      if (wrDot) dotLevel_q[regIdx] <= regWrData;
      if (wrPwm) pwmSet_q[regIdx] <= regWrData;
      if (wrShape) shape_q[regIdx] <= regWrData;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------------
  wire [2:0] ledMode = modeCfg_q[MODE_LSB +: 3];
  wire rateLow = modeCfg_q[RATE_BIT];
  wire [3:0] mixSel = modeCfg_q[MIX_LSB +: 4];
  wire clampEn = !driveCfg_q[CLAMP_DIS_BIT];
  wire clampOffTime = driveCfg_q[CLAMP_SEL_BIT];
  wire blankLong = driveCfg_q[BLANK_SEL_BIT];
  wire syncOutEn = driveCfg_q[SYNC_OUT_BIT];

  wire directMode = (ledMode == MODE_DIRECT);
  // mixed modes take scan count from mode minus four
  wire mixMode = (ledMode > MODE_MIX_BASE);
  // matrix scan count equals mode value
  wire [2:0] scanCount = mixMode ? 3'(ledMode - MODE_MIX_BASE) : ledMode;
  wire [3:0] directMask = directMode ? 4'hf : (mixMode ? mixSel : 4'h0);
  wire [6:0] blankLen = blankLong ? BLANK_LONG_CYC : BLANK_SHORT_CYC;

  // ----------------------------------------------------------------------
  // Time base and sync pin
  // ----------------------------------------------------------------------
  logic [15:0] oscAcc_q;
  logic syncMeta_q;
  logic syncSync_q;
  logic syncLast_q;
  logic syncOut_q;
  logic syncOe_n_q;
  logic halfPhase_q;

  // fractional divider gives 6 MHz ticks from core clock
  wire oscTick = (oscAcc_q >= OSC_WRAP);
  wire [15:0] oscAcc_d = oscTick ? 16'(oscAcc_q - OSC_WRAP) : 16'(oscAcc_q + OSC_STEP);
  wire extEdge = syncSync_q ^ syncLast_q;
  // tick source is own oscillator or sync pin edges
  wire pwmTick = syncOutEn ? oscTick : extEdge;
  // low rate takes every second tick
  wire pwmStep = pwmTick && (!rateLow || halfPhase_q);

  // Oscillator accumulator and rate halver
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscAcc_q <= 16'h0000;
      halfPhase_q <= 1'b0;
    end else begin
      oscAcc_q <= oscAcc_d;
      if (pwmTick) halfPhase_q <= !halfPhase_q;
    end
  end

  // Sync pin: two-stage input sync, toggle output at tick rate
  // pin direction follows drive bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncMeta_q <= 1'b0;
      syncSync_q <= 1'b0;
      syncLast_q <= 1'b0;
      syncOut_q <= 1'b0;
      syncOe_n_q <= 1'b1;
    end else begin
      syncMeta_q <= syncIn;
      syncSync_q <= syncMeta_q;
      syncLast_q <= syncSync_q;
      if (oscTick) syncOut_q <= !syncOut_q;
      syncOe_n_q <= !syncOutEn;
    end
  end

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  lmd_scan_state_t state_q;
  logic [1:0] slot_q;
  logic [7:0] pwmCnt_q;
  logic [6:0] blankCnt_q;

  wire periodEnd = pwmStep && (pwmCnt_q == 8'hff);
  wire blankDone = (blankCnt_q == 7'(blankLen - 7'h01));
  wire slotWrap = ({1'b0, slot_q} + 3'h1) >= scanCount;
  wire [1:0] slotNext = slotWrap ? 2'h0 : 2'(slot_q + 2'h1);
  wire slotValid = ({1'b0, slot_q} < scanCount);
  // slot selects output from its order field
  wire [1:0] activeOut = scanCfg_q[{slot_q, 1'b0} +: 2];

  // one PWM period per slot, then blank of chosen length
  // slots advance in order, wrapping at scan count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= LMD_DIM;
      slot_q <= 2'h0;
      pwmCnt_q <= 8'h00;
      blankCnt_q <= 7'h00;
    end else begin
      case (state_q)
        LMD_DIM: begin
          if (pwmStep) pwmCnt_q <= 8'(pwmCnt_q + 8'h01);
          if (periodEnd && !directMode) begin
            state_q <= LMD_BLANK;
            blankCnt_q <= 7'h00;
          end
        end
        LMD_BLANK: begin
          blankCnt_q <= 7'(blankCnt_q + 7'h01);
          pwmCnt_q <= 8'h00;
          if (blankDone) begin
            state_q <= LMD_DIM;
            slot_q <= slotNext;
          end
        end
        default: begin
          state_q <= LMD_DIM;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Per-output drive decode
  // ----------------------------------------------------------------------
  wire inDim = (state_q == LMD_DIM);
  wire inBlank = (state_q == LMD_BLANK);
  lmd_drive_t drive_d;
  logic [7:0] level_d [NUM_OUT];

  for (genvar x = 0; x < NUM_OUT; x++) begin : g_out
    wire isDirect = directMask[x];
    wire isSwitch = !directMode && !isDirect && slotValid && (activeOut == 2'(x));
    // matrix dot index from distance to active switch
    wire [3:0] idx = ledIndex(2'(x), activeOut, isDirect);
    // zero is dark, 255 fully on
    wire [8:0] duty = dutyOf(pwmSet_q[idx], shape_q[idx][EXP_BIT]);
    wire pulse = pwmOn(pwmCnt_q, duty, shape_q[idx][ALIGN_LSB +: 2]);
    // matrix sink only when another output is switch in a valid slot
    wire matrixSink = !isDirect && !directMode && slotValid && !isSwitch &&
                      !directMask[activeOut];
    // blank turns every switch and sink off
    assign drive_d.scanOn[x] = inDim && isSwitch;
    assign drive_d.sinkOn[x] = inDim && (isDirect || matrixSink) && pulse;
    // clamp in off time or blank only
    assign drive_d.clampOn[x] = clampEn && !directMode && !drive_d.scanOn[x] &&
                                !drive_d.sinkOn[x] && (inBlank || clampOffTime);
    // direct channels use direct levels, others matrix dot levels
    assign level_d[x] = dotLevel_q[idx];
  end

  // Registered drive outputs
  logic [11:0] drive_q;
  logic [31:0] level_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_q <= 12'h000;
      level_q <= 32'h00000000;
    end else begin
      drive_q <= drive_d;
      level_q <= {level_d[3], level_d[2], level_d[1], level_d[0]};
    end
  end

  // ----------------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------------
  wire [7:0] statusWord = {state_q, slot_q, activeOut, scanCount};
  wire [7:0] rdMux =
    (regAddr == ADDR_CFG_MODE) ? modeCfg_q :
    (regAddr == ADDR_CFG_SCAN) ? scanCfg_q :
    (regAddr == ADDR_CFG_DRIVE) ? driveCfg_q :
    (regAddr == ADDR_STATUS) ? statusWord :
    (regAddr == ADDR_PWM_COUNT) ? pwmCnt_q :
    (regAddr[5:4] == BANK_DOT) ? dotLevel_q[regIdx] :
    (regAddr[5:4] == BANK_PWM) ? pwmSet_q[regIdx] :
    (regAddr[5:4] == BANK_SHAPE) ? shape_q[regIdx] : 8'h00;

  // Read data holds only the cycle after a read strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_q <= 8'h00;
    end else begin
      regRdData_q <= regRdEn ? rdMux : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------------
  assign regRdData = regRdData_q;
  assign syncOut = syncOut_q;
  assign syncOe_n = syncOe_n_q;
  assign drive = drive_q;
  assign sinkLevel = level_q;
  assign fullScale = driveCfg_q[FULL_SCALE_BIT];
  assign vmidSel = driveCfg_q[VMID_LSB +: 2];

endmodule // lmd_scan_pwm

// ---- verification/lmd_led_array.sv ----
// LED array model on the four outputs: counts lit cycles of each dot.
// Assumes drive levels change only after rising core_clk edges.
`timescale 1ns/1ns
module lmd_led_array
  import lmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic clr,
  input wire logic [3:0] dMask,
  input lmd_drive_t drive,
  output logic [NUM_LED-1:0][15:0] litCnt,
  output logic [15:0] clampCnt,
  output logic [7:0] scanSeq
);
  logic [15:0] lit;
  logic anyScanQ;
  wire logic [1:0] scanIdx = {drive.scanOn[3] | drive.scanOn[2], drive.scanOn[3] | drive.scanOn[1]};

  always_comb begin
    lit = '0;
    for (int k = 0; k < 4; k++) begin
      lit[k] = drive.sinkOn[k] & dMask[k];
      for (int j = 0; j < 3; j++)
        lit[4+3*k+j] = drive.scanOn[k] & drive.sinkOn[(k+1+j)%4] & ~dMask[(k+1+j)%4];
    end
  end

  always_ff @(posedge core_clk) begin
    anyScanQ <= |drive.scanOn;
    if (clr) begin
      litCnt <= '0;
      clampCnt <= '0;
    end else begin
      for (int i = 0; i < NUM_LED; i++)
        litCnt[i] <= litCnt[i] + 16'(lit[i]);
      clampCnt <= clampCnt + 16'(|drive.clampOn);
    end
    if (|drive.scanOn && !anyScanQ)
      scanSeq <= {scanSeq[5:0], scanIdx};
  end
endmodule // lmd_led_array

// ---- verification/lmd_scan_pwm_monitor.sv ----
// Checker of scan, clamp, config and sync pin timing.
// Sees only the top ports; bound at the foot of this file.
`timescale 1ns/1ns
module lmd_scan_pwm_monitor
  import lmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic syncIn,
  input wire logic syncOut,
  input wire logic syncOe_n,
  input lmd_drive_t drive,
  input wire logic [4*NUM_OUT-1+16:0] sinkLevel,
  input wire logic fullScale,
  input wire logic [1:0] vmidSel
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] modeQ;
  logic [7:0] cfgQ;

  // Shadow of mode and drive config
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeQ <= MODE_RST;
      cfgQ <= DRIVE_RST;
    end else if (regWrEn && regAddr == ADDR_CFG_MODE) begin
      modeQ <= regWrData;
    end else if (regWrEn && regAddr == ADDR_CFG_DRIVE) begin
      cfgQ <= regWrData;
    end
  end

  property p_one_switch;
    $onehot0(drive.scanOn);
  endproperty
  a_one_switch: assert property (p_one_switch) else $error("two scan switches on");
  property p_switch_sink;
    (drive.scanOn & drive.sinkOn) == 4'h0;
  endproperty
  a_switch_sink: assert property (p_switch_sink) else $error("switch also sinks");
  property p_blank;
    $fell(|drive.scanOn) && modeQ[2:0] != MODE_DIRECT && $past(modeQ, 4) == modeQ
      |-> (drive.scanOn == 4'h0 && drive.sinkOn == 4'h0) [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("output on in blank");
  property p_clamp_dis;
    cfgQ[CLAMP_DIS_BIT] && $past(cfgQ[CLAMP_DIS_BIT], 2) |-> drive.clampOn == 4'h0;
  endproperty
  a_clamp_dis: assert property (p_clamp_dis) else $error("clamp while disabled");
  property p_clamp_sel;
    !cfgQ[CLAMP_SEL_BIT] && !$past(cfgQ[CLAMP_SEL_BIT], 2) && |drive.scanOn
      |-> drive.clampOn == 4'h0;
  endproperty
  a_clamp_sel: assert property (p_clamp_sel) else $error("clamp outside blank");
  property p_cfg_out;
    regWrEn && regAddr == ADDR_CFG_DRIVE
      |=> {fullScale, vmidSel} == {$past(regWrData[FULL_SCALE_BIT]), $past(regWrData[3:2])};
  endproperty
  a_cfg_out: assert property (p_cfg_out) else $error("scale or level wrong");
  property p_sync_oe;
    regWrEn && regAddr == ADDR_CFG_DRIVE |=> ##1 syncOe_n == !cfgQ[SYNC_OUT_BIT];
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync enable wrong");
  property p_sync_rate;
    @(posedge core_clk) disable iff (!arst_n || syncOe_n)
      $changed(syncOut) |=> $stable(syncOut) [*6] ##[1:3] $changed(syncOut);
  endproperty
  a_sync_rate: assert property (p_sync_rate) else $error("sync clock rate wrong");
  property p_direct;
    modeQ[2:0] == MODE_DIRECT && $past(modeQ, 3) == modeQ |-> drive.scanOn == 4'h0;
  endproperty
  a_direct: assert property (p_direct) else $error("scan in direct mode");
endmodule // lmd_scan_pwm_monitor

bind lmd_scan_pwm lmd_scan_pwm_monitor u_lmd_scan_pwm_monitor (.core_clk(core_clk),
  .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .syncIn(syncIn), .syncOut(syncOut),
  .syncOe_n(syncOe_n), .drive(drive), .sinkLevel(sinkLevel), .fullScale(fullScale),
  .vmidSel(vmidSel));

// ---- verification/tb.sv ----
// Self-checking bench of the scan and PWM dimmer with an LED array model.
// Assumes the bench supplies the sync clock once export is switched off.
`timescale 1ns/1ns
module tb;
  import lmd_pkg::*;
  typedef struct {
    logic [7:0] s;
    logic [7:0] sh;
    logic r;
    int d;
  } lmd_row_t;
  logic core_clk, arst_n, regWrEn, regRdEn, extSync, clr, syncOut, syncOe_n, fullScale;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, rv, scanSeq;
  logic [1:0] vmidSel;
  logic [4*NUM_OUT-1+16:0] sinkLevel;
  logic [3:0] dMask;
  lmd_drive_t drive;
  logic [15:0] clampCnt;
  logic [NUM_LED-1:0][15:0] litCnt;
  int failures = 0;
  int compares = 0;
  wire logic syncPin = syncOe_n ? extSync : syncOut;
  lmd_row_t rows [10] = '{'{8'h00, 8'h0, 1'b0, 0}, '{8'hff, 8'h0, 1'b0, 256},
    '{8'h64, 8'h0, 1'b0, 100}, '{8'h64, 8'h1, 1'b0, 100}, '{8'h65, 8'h1, 1'b0, 101},
    '{8'h64, 8'h2, 1'b0, 100}, '{8'hc8, 8'h3, 1'b0, 200}, '{8'h80, 8'h4, 1'b0, 32},
    '{8'hff, 8'h4, 1'b0, 256}, '{8'h64, 8'h0, 1'b1, 100}};
  logic [5:0] rAd [7] = '{6'h00, 6'h01, 6'h02, 6'h10, 6'h20, 6'h30, 6'h0f};
  logic [7:0] rEx [7] = '{MODE_RST, SCAN_RST, DRIVE_RST, DOT_RST, PWM_RST, SHAPE_RST, 8'h00};

  lmd_scan_pwm u_lmd_scan_pwm (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .syncIn(syncPin), .syncOut(syncOut), .syncOe_n(syncOe_n), .drive(drive),
    .sinkLevel(sinkLevel), .fullScale(fullScale), .vmidSel(vmidSel));
  lmd_led_array u_lmd_led_array (.core_clk(core_clk), .clr(clr), .dMask(dMask),
    .drive(drive), .litCnt(litCnt), .clampCnt(clampCnt), .scanSeq(scanSeq));

  // --------------------
  // Tasks
  // --------------------
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic tick(int n);
    repeat (n) begin
      extSync <= ~extSync;
      repeat (8) @(posedge core_clk);
    end
  endtask

  task automatic frame(logic [15:0] exp);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    tick(1100);
    for (int i = 0; i < NUM_LED; i++)
      check("dot", 32'(litCnt[i] != 0), 32'(exp[i]));
  endtask

  task automatic print_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // --------------------
  // Clock, watchdog, sequence
  // --------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #1600000;
    failures++;
    print_verdict();
  end

  initial begin
    int n, on, bad, st, c;
    logic sv;
    arst_n = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    extSync = 1'b0;
    clr = 1'b0;
    dMask = 4'hf;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    n = 0;
    sv = 1'b0;
    repeat (120) begin
      @(posedge core_clk);
      if (syncOut !== sv) n++;
      sv = syncOut;
    end
    check("syncrate", 32'(n >= 12 && n <= 15), 1);
    check("syncexp", syncOe_n, 0);
    wr(ADDR_CFG_DRIVE, 8'h00);
    repeat (3) @(posedge core_clk);
    check("syncimp", syncOe_n, 1);
    for (int r = 0; r < 10; r++) begin
      wr(6'h20, rows[r].s);
      wr(6'h30, rows[r].sh);
      wr(ADDR_CFG_MODE, {4'h0, rows[r].r, 3'h0});
      rd(ADDR_PWM_COUNT, rv);
      on = 0;
      bad = 0;
      st = rows[r].sh[1:0] == ALIGN_MID ? (256 - rows[r].d) >> 1 :
           rows[r].sh[1:0] == ALIGN_BWD ? 256 - rows[r].d : 0;
      for (int t = 0; t < (256 << rows[r].r); t++) begin
        tick(1);
        c = (rv + 1 + t) % 256;
        if (drive.sinkOn[0] === 1'b1) on++;
        if (!rows[r].r && drive.sinkOn[0] !== (c >= st && c < st + rows[r].d)) bad++;
      end
      check("duty", on, rows[r].d << rows[r].r);
      check("align", bad, 0);
    end
    wr(6'h20, 8'hff);
    wr(6'h10, 8'h5a);
    tick(2);
    check("level", sinkLevel[7:0], 8'h5a);
    wr(6'h24, 8'hff);
    wr(6'h28, 8'hff);
    wr(6'h2f, 8'hff);
    dMask <= 4'h0;
    wr(ADDR_CFG_MODE, 8'h04);
    frame(16'h8110);
    check("order", 2'(scanSeq[1:0] - scanSeq[3:2]), 1);
    check("clamp", 32'(clampCnt != 0), 1);
    wr(ADDR_CFG_DRIVE, 8'h2d);
    wr(ADDR_CFG_MODE, 8'h02);
    frame(16'h0110);
    check("clampoff", clampCnt, 0);
    check("cfg", {fullScale, vmidSel}, 3'h7);
    wr(6'h26, 8'hff);
    dMask <= 4'h8;
    wr(ADDR_CFG_MODE, 8'h85);
    frame(16'h0010);
    wr(6'h23, 8'hff);
    frame(16'h0018);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("rstdrive", drive, 0);
    check("rstlevel", sinkLevel, 0);
    check("rstoe", syncOe_n, 1);
    arst_n <= 1'b1;
    wr(6'h0f, 8'hff);
    for (int i = 0; i < 7; i++) begin
      rd(rAd[i], rv);
      check("regreset", rv, rEx[i]);
    end
    print_verdict();
  end
endmodule // tb
